// ===== inc/ltq_pkg.sv
// Constants and types shared by the level trigger acquisition sequencer
package ltq_pkg;

	localparam int unsigned CLK_MHZ = 25;
	// Trigger recognition delay, ns, least figure
	localparam int unsigned TRIG_RECOG_NS = 20;
	localparam int unsigned TRIG_RECOG_CYC =
		((TRIG_RECOG_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 : (TRIG_RECOG_NS * CLK_MHZ + 999) / 1000;
	// Cycles per microsecond tick
	localparam int unsigned US_CYC = CLK_MHZ;
	localparam logic [4:0] US_LAST = 5'(US_CYC - 1);

	// Variant select
	localparam logic [1:0] VAR_A = 2'h0;
	localparam logic [1:0] VAR_B = 2'h1;
	localparam logic [1:0] VAR_C = 2'h2;

	// Initial busy interval, us, per variant
	localparam logic [23:0] BUSY1_A_US = 24'h000001;
	localparam logic [23:0] BUSY1_B_US = 24'h000e7a;
	localparam logic [23:0] BUSY1_C_US = 24'h000006;
	// Final busy interval, us, per variant
	localparam logic [23:0] BUSY2_A_US = 24'h0000da;
	localparam logic [23:0] BUSY2_B_US = 24'h000e7a;
	localparam logic [23:0] BUSY2_C_US = 24'h001371;
	// Least level pulse width, us, per variant
	localparam logic [23:0] MINPUL_A_US = 24'h0000dc;
	localparam logic [23:0] MINPUL_B_US = 24'h000ed8;
	localparam logic [23:0] MINPUL_C_US = 24'h001c20;
	// Longest level pulse width, us, per variant (6 s, 10 s, 5 s)
	localparam logic [23:0] MAXPUL_A_US = 24'h5b8d80;
	localparam logic [23:0] MAXPUL_B_US = 24'h989680;
	localparam logic [23:0] MAXPUL_C_US = 24'h4c4b40;
	// Largest acquisition delay, us
	localparam logic [23:0] ACQ_DELAY_MAX_US = 24'h051e8c;

	typedef enum {
		LTQ_IDLE,
		LTQ_RECOG,
		LTQ_BUSY1,
		LTQ_ACQDLY,
		LTQ_INTEG,
		LTQ_BUSY2
	} ltq_state_t;

endpackage

// ===== verilog/ltq_strobe.sv
// Single and continuous strobe generator, counted in microsecond ticks
module ltq_strobe
	import ltq_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        integ_active,
	input  wire logic        us_tick,
	input  wire logic        single_en,
	input  wire logic [23:0] single_delay_us,
	input  wire logic [23:0] single_width_us,
	input  wire logic        cont_en,
	input  wire logic [23:0] cont_period_us,
	output logic             single_strobe,
	output logic             cont_strobe
);

	typedef struct packed {
		logic [23:0] s_cnt;
		logic [23:0] c_cnt;
		logic        single;
		logic        cont;
	} ltq_strobe_s_t;

	ltq_strobe_s_t r;
	ltq_strobe_s_t next_r;
	logic [23:0]   half;

	assign half = {1'b0, cont_period_us[23:1]};

	// Both strobes run only inside integration and drop when it ends
	always_comb begin
		next_r = r;
		if (!integ_active) begin
			next_r = '0;
		end else if (us_tick) begin
			next_r.s_cnt = r.s_cnt + 24'h000001;
			// Same single strobe timing as every other trigger mode
			next_r.single = single_en && (single_width_us != 24'h000000) &&
				(r.s_cnt >= single_delay_us) &&
				(r.s_cnt < single_delay_us + single_width_us);
			// Half period high, half low; period zero keeps it quiet
			if (cont_en && cont_period_us > 24'h000001) begin
				next_r.c_cnt = (r.c_cnt + 24'h000001 >= cont_period_us) ? 24'h000000 :
					r.c_cnt + 24'h000001;
				next_r.cont = (r.c_cnt < half);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign single_strobe = r.single;
	assign cont_strobe   = r.cont;

endmodule

// ===== verilog/ltq_sequencer.sv
// Level trigger acquisition sequencer: trigger, busy, delay, integrate, readout busy
module ltq_sequencer
	import ltq_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        level_mode,
	input  wire logic [1:0]  variant,
	input  wire logic        ext_trigger,
	input  wire logic [23:0] acquisition_delay,
	input  wire logic [23:0] sw_integration_time,
	input  wire logic        single_en,
	input  wire logic [23:0] single_delay_us,
	input  wire logic [23:0] single_width_us,
	input  wire logic        cont_en,
	input  wire logic [23:0] continuous_strobe_period,
	output logic             trigger_event,
	output logic             busy,
	output logic             integrating,
	output logic             acq_done,
	output logic             pulse_error,
	output logic             zero_spectrum,
	output logic             pulse_too_long,
	output logic [23:0]      integration_time,
	output logic             single_strobe,
	output logic             cont_strobe
);

	typedef struct packed {
		logic [1:0]  trig_sync;
		logic        trig_prev;
		ltq_state_t  state;
		logic [4:0]  pre;
		logic [4:0]  recog;
		logic [23:0] us_cnt;
		logic        us_tick;
		logic        trig_evt;
		logic        busy;
		logic        integ;
		logic        done;
		logic        err;
		logic        zero;
		logic        too_long;
		logic        fell;
		logic [23:0] integ_us;
	} ltq_seq_s_t;

	ltq_seq_s_t  r;
	ltq_seq_s_t  next_r;
	logic        trig_s;
	logic        trig_rise;
	logic [23:0] busy1_us;
	logic [23:0] busy2_us;
	logic [23:0] minpul_us;
	logic [23:0] maxpul_us;
	logic [23:0] acq_lim;
	logic        strobe_gate;

	assign trig_s    = r.trig_sync[1];
	assign trig_rise = trig_s && !r.trig_prev;
	assign acq_lim   = (acquisition_delay > ACQ_DELAY_MAX_US) ? ACQ_DELAY_MAX_US :
		acquisition_delay;
	// Strobe flops see the end one cycle early, so they drop together with integrating
	assign strobe_gate = r.integ && next_r.integ;

	// Per-variant constant intervals
	always_comb begin
		case (variant)
			VAR_B: begin
				busy1_us  = BUSY1_B_US;
				busy2_us  = BUSY2_B_US;
				minpul_us = MINPUL_B_US;
				maxpul_us = MAXPUL_B_US;
			end
			VAR_C: begin
				busy1_us  = BUSY1_C_US;
				busy2_us  = BUSY2_C_US;
				minpul_us = MINPUL_C_US;
				maxpul_us = MAXPUL_C_US;
			end
			default: begin
				busy1_us  = BUSY1_A_US;
				busy2_us  = BUSY2_A_US;
				minpul_us = MINPUL_A_US;
				maxpul_us = MAXPUL_A_US;
			end
		endcase
	end

	// Sequencer; the pin passes two flops, so recognition counts from the synced edge
	always_comb begin
		next_r           = r;
		next_r.trig_sync = {r.trig_sync[0], ext_trigger};
		next_r.trig_prev = trig_s;
		next_r.trig_evt  = 1'b0;
		next_r.done      = 1'b0;
		next_r.us_tick   = 1'b0;
		// Microsecond prescaler restarts with each phase so phases are whole us
		if (r.pre == US_LAST) begin
			next_r.pre     = 5'h00;
			next_r.us_tick = 1'b1;
		end else begin
			next_r.pre = r.pre + 5'h01;
		end
		case (r.state)
			LTQ_IDLE: begin
				next_r.busy  = 1'b0;
				next_r.integ = 1'b0;
				if (level_mode && trig_rise) begin
					next_r.state = LTQ_RECOG;
					next_r.recog = 5'h00;
					next_r.busy  = 1'b1;
					next_r.err   = 1'b0;
					next_r.zero  = 1'b0;
					next_r.too_long = 1'b0;
					next_r.fell  = 1'b0;
				end
			end
			LTQ_RECOG: begin
				next_r.recog = r.recog + 5'h01;
				if (r.recog + 5'h01 >= 5'(TRIG_RECOG_CYC)) begin
					next_r.trig_evt = 1'b1;
					next_r.state    = LTQ_BUSY1;
					next_r.pre      = 5'h00;
					next_r.us_tick  = 1'b0;
					next_r.us_cnt   = 24'h000000;
				end
			end
			LTQ_BUSY1, LTQ_ACQDLY: begin
				if (!trig_s) begin
					next_r.fell = 1'b1;
				end
				if (r.us_tick) begin
					next_r.us_cnt = r.us_cnt + 24'h000001;
				end
				if (r.state == LTQ_BUSY1 && r.us_tick && r.us_cnt + 24'h000001 >= busy1_us) begin
					next_r.state  = (acq_lim == 24'h000000) ? LTQ_INTEG : LTQ_ACQDLY;
					next_r.us_cnt = 24'h000000;
					next_r.integ  = (acq_lim == 24'h000000);
					next_r.pre    = 5'h00;
				end else if (r.state == LTQ_ACQDLY && r.us_tick &&
					r.us_cnt + 24'h000001 >= acq_lim) begin
					next_r.state  = LTQ_INTEG;
					next_r.us_cnt = 24'h000000;
					next_r.integ  = 1'b1;
					next_r.pre    = 5'h00;
				end
			end
			LTQ_INTEG: begin
				// Software integration time is not used; the pulse level ends it
				if (r.us_tick && r.us_cnt != 24'hffffff) begin
					next_r.us_cnt = r.us_cnt + 24'h000001;
				end
				if (!trig_s || r.fell) begin
					next_r.state    = LTQ_BUSY2;
					next_r.integ    = 1'b0;
					next_r.integ_us = r.us_cnt;
					next_r.us_cnt   = 24'h000000;
					next_r.pre      = 5'h00;
					next_r.too_long = (r.us_cnt > maxpul_us);
					// Short pulse: pin fell before integration, or integration time below the variant minimum
					if (r.fell || r.us_cnt < minpul_us) begin
						next_r.err  = 1'b1;
						next_r.zero = 1'b1;
					end
				end
			end
			LTQ_BUSY2: begin
				if (r.us_tick) begin
					next_r.us_cnt = r.us_cnt + 24'h000001;
				end
				if (r.us_tick && r.us_cnt + 24'h000001 >= busy2_us) begin
					next_r.state = LTQ_IDLE;
					next_r.busy  = 1'b0;
					next_r.done  = 1'b1;
				end
			end
			default: begin
				next_r.state = LTQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Strobe timing in its own module; it only sees the integration window
	ltq_strobe u_strobe (
		.mclk            (mclk),
		.resetn          (resetn),
		.integ_active    (strobe_gate),
		.us_tick         (r.us_tick),
		.single_en       (single_en),
		.single_delay_us (single_delay_us),
		.single_width_us (single_width_us),
		.cont_en         (cont_en),
		.cont_period_us  (continuous_strobe_period),
		.single_strobe   (single_strobe),
		.cont_strobe     (cont_strobe)
	);

	assign trigger_event    = r.trig_evt;
	assign busy             = r.busy;
	assign integrating      = r.integ;
	assign acq_done         = r.done;
	assign pulse_error      = r.err;
	assign zero_spectrum    = r.zero;
	assign pulse_too_long   = r.too_long;
	assign integration_time = r.integ_us;

endmodule

// ===== test/ltq_sequencer_assertions.sv
// Port-level checks for the level trigger acquisition sequencer
module ltq_sequencer_assertions
	import ltq_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ext_trigger,
	input wire logic trigger_event,
	input wire logic busy,
	input wire logic integrating,
	input wire logic acq_done,
	input wire logic pulse_error,
	input wire logic zero_spectrum,
	input wire logic single_strobe,
	input wire logic cont_strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned since_evt;
	// Cycles since the last event; saturates so a long idle spell cannot wrap
	always_ff @(posedge mclk) begin
		if (!resetn || trigger_event)
			since_evt <= 0;
		else if (since_evt < 100000)
			since_evt <= since_evt + 1;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence s_accept;
		$rose(busy);
	endsequence
	sequence s_event;
		trigger_event ##1 !trigger_event;
	endsequence
	chk_start_needs_pin: assert property (s_accept |-> $past(ext_trigger))
		else $error("busy rose with the trigger pin low");
	chk_event_one_pulse: assert property (s_accept |=> s_event)
		else $error("trigger event missing or too long");
	chk_busy1_wait: assert property ($rose(integrating) |-> since_evt >= 24)
		else $error("integration began too soon after the event");
	chk_integ_stops: assert property ($fell(ext_trigger) |-> ##[1:5] !integrating)
		else $error("integration outlived the pulse");
	chk_integ_pin_end: assert property ($fell(integrating) |-> !$past(ext_trigger, 2))
		else $error("integration ended with the pin still high");
	chk_busy2_hold: assert property ($fell(integrating) |-> busy [*8])
		else $error("busy dropped right after integration");
	chk_done_at_end: assert property ($fell(busy) |-> acq_done)
		else $error("busy ended without done");
	chk_single_low: assert property (!integrating |-> !single_strobe)
		else $error("single strobe outside integration");
	chk_cont_low: assert property (!integrating |-> !cont_strobe)
		else $error("continuous strobe outside integration");
	chk_error_zero: assert property (pulse_error |-> zero_spectrum)
		else $error("error flagged without zero spectrum");
endmodule

// ===== test/ltq_trigger_source.sv
// External trigger source model: one level pulse of a commanded width
module ltq_trigger_source (
	input wire logic        mclk,
	input wire logic        go,
	input wire logic [31:0] width,
	output logic            ext_trigger
);
	timeunit 1ns;
	timeprecision 1ns;
	int n = 0;
	// Command taken at the rising edge, where the bench's falling-edge writes have settled
	always @(posedge mclk) begin
		if (go)
			n = width;
		else if (n != 0)
			n = n - 1;
	end
	// Pin idles low, held high exactly width cycles; moves clear of the sampling edge
	always @(negedge mclk) begin
		ext_trigger = (n != 0);
	end
endmodule

// ===== test/ltq_sequencer_bench.sv
// Self-checking bench for the level trigger acquisition sequencer
module ltq_sequencer_bench import ltq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk, resetn, level_mode, go, single_en, cont_en, ext_trigger, cs_q, tclr;
	logic [1:0]  variant;
	logic [23:0] acquisition_delay, integration_time;
	logic        trigger_event, busy, integrating, acq_done, pulse_error, zero_spectrum;
	logic        pulse_too_long, single_strobe, cont_strobe;
	logic [31:0] width;
	int          num_errors, check_count, n_evt, n_int, n_ss, n_cs;
	ltq_sequencer i_dut (.mclk(mclk), .resetn(resetn), .level_mode(level_mode),
		.variant(variant), .ext_trigger(ext_trigger), .acquisition_delay(acquisition_delay),
		.sw_integration_time(24'h000064), .single_en(single_en), .single_delay_us(24'h000005),
		.single_width_us(24'h00000a), .cont_en(cont_en), .continuous_strobe_period(24'h000014),
		.trigger_event(trigger_event), .busy(busy), .integrating(integrating),
		.acq_done(acq_done), .pulse_error(pulse_error), .zero_spectrum(zero_spectrum),
		.pulse_too_long(pulse_too_long), .integration_time(integration_time),
		.single_strobe(single_strobe), .cont_strobe(cont_strobe));
	ltq_trigger_source i_src (.mclk(mclk), .go(go), .width(width), .ext_trigger(ext_trigger));
	// 25 MHz clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// Event, integration and strobe tallies per acquisition, read where outputs are settled
	always @(negedge mclk) begin
		if (tclr) begin
			{n_evt, n_int, n_ss, n_cs} = 0;
		end else begin
			n_evt += trigger_event;
			n_int += integrating;
			n_ss += single_strobe;
			n_cs += (cont_strobe & !cs_q);
		end
		cs_q = cont_strobe;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		check_count++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			num_errors++;
			$display("Error %0t got %h exp %h..%h", $time, got, lo, hi);
		end
	endtask
	// Fires one pulse of w_us and waits, bounded, for the acquisition to close
	task acq(input int w_us, input logic [23:0] dly);
		int k;
		@(negedge mclk);
		tclr <= 1'b1;
		acquisition_delay = dly;
		width = 32'(w_us * 25);
		go = 1'b1;
		@(negedge mclk);
		go = 1'b0;
		tclr <= 1'b0;
		for (k = 0; k < 40000 && acq_done !== 1'b1; k++)
			@(negedge mclk);
		chk(acq_done, 1);
	endtask
	// A pulse outside level mode starts nothing, and busy stays low after level mode is set
	task t_idle;
		level_mode = 1'b0;
		width = 32'h1f4;
		go = 1'b1;
		@(negedge mclk) go = 1'b0;
		repeat (700) @(negedge mclk);
		chk(n_evt, 0);
		chk(busy, 0);
		level_mode = 1'b1;
		repeat (100) @(negedge mclk);
		chk(busy, 0);
	endtask
	// Short pulse, then a second pulse rising in the final busy spell is ignored
	task t_short;
		fork
			acq(200, 24'h0);
			begin
				repeat (5200) @(negedge mclk);
				go = 1'b1;
				width = 32'h9c4;
				@(negedge mclk) go = 1'b0;
			end
		join
		repeat (2600) @(negedge mclk);
		chk(n_evt, 1);
		chk(pulse_error, 1);
		chk(zero_spectrum, 1);
	endtask
	task t_nominal;
		acq(300, 24'h3);
		chk(n_evt, 1);
		chk_rng(n_int, 7370, 7430);
		chk_rng(integration_time, 294, 297);
		chk(pulse_error, 0);
		chk(zero_spectrum, 0);
		chk(pulse_too_long, 0);
		chk_rng(n_ss, 248, 252);
		chk_rng(n_cs, 14, 15);
	endtask
	// Variant C: 6 us initial busy; 50 us is short; a reset cuts the long final busy
	task t_var_c;
		int k;
		variant = VAR_C;
		acquisition_delay = 24'h000000;
		width = 32'h4e2;
		go = 1'b1;
		@(negedge mclk) go = 1'b0;
		for (k = 0; k < 100 && trigger_event !== 1'b1; k++)
			@(negedge mclk);
		for (k = 0; k < 400 && integrating !== 1'b1; k++)
			@(negedge mclk);
		chk_rng(k, 150, 152);
		for (k = 0; k < 2000 && integrating !== 1'b0; k++)
			@(negedge mclk);
		chk(pulse_error, 1);
		chk(zero_spectrum, 1);
		repeat (10) @(negedge mclk);
		chk(busy, 1);
		resetn = 1'b0;
		repeat (2) @(negedge mclk);
		chk(busy, 0);
		chk(pulse_error, 0);
		resetn = 1'b1;
		variant = VAR_A;
		repeat (3) @(negedge mclk);
		chk(busy, 0);
	endtask
	task wrap_up;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Main sequence: reset for 20 cycles, then the scenarios
	initial begin
		{resetn, level_mode, go, single_en, cont_en, tclr} = 0;
		variant = 2'h0;
		acquisition_delay = 24'h0;
		width = 32'h0;
		repeat (20) @(negedge mclk);
		resetn = 1'b1;
		single_en = 1'b1;
		cont_en = 1'b1;
		repeat (3) @(negedge mclk);
		t_idle;
		t_short;
		t_nominal;
		t_var_c;
		wrap_up;
	end
	// Watchdog: the scenarios need about 28000 cycles
	initial begin
		repeat (60000) @(posedge mclk);
		num_errors++;
		wrap_up;
	end
endmodule
bind ltq_sequencer ltq_sequencer_assertions i_chk (.mclk(mclk), .resetn(resetn),
	.ext_trigger(ext_trigger), .trigger_event(trigger_event), .busy(busy),
	.integrating(integrating), .acq_done(acq_done), .pulse_error(pulse_error),
	.zero_spectrum(zero_spectrum), .single_strobe(single_strobe), .cont_strobe(cont_strobe));
